// file: inc/coulomb_params.svh
// Purpose: constants of the charge-accounting core
// Assumes: 40 MHz system clock
// Notes: times in ns, cycle counts derived from them
`ifndef COULOMB_PARAMS_SVH
`define COULOMB_PARAMS_SVH

`define CLK_NS 25
`define CEIL_CYC(ns) (((ns) + `CLK_NS - 1) / `CLK_NS)
`define FLOOR_CYC(ns) ((ns) / `CLK_NS)

`define TICK_NS 878900000
`define SLOW_LAST 8'hff
`define CNT_MAX 16'hffff

`define RAM_BYTES 32
`define FLASH_BASE_NS 60000
`define FLASH_BYTE_NS 30000
`define PROG_NS (`FLASH_BASE_NS + `FLASH_BYTE_NS * `RAM_BYTES)

`define BREAK_NS 190000
`define ONE_LIMIT_NS 75000
`define ONE_LIMIT_CYC 16'(`FLOOR_CYC(`ONE_LIMIT_NS))
`define RESP_NS 250000
`define DBIT_NS 220000
`define DONE_NS 40000
`define DONE_CYC 16'(`CEIL_CYC(`DONE_NS))
`define DZERO_NS 110000
`define BYTE_LAST 4'h7

`define RES_POS 4'h3
`define RES_NEG 4'hd

`define SD_W_NOM 16'h0010
`define SD_T_NOM 25
`define SD_T_STEP 10
`define SD_T_MIN 0
`define SD_T_MAX 60

`define REG_CHG_ACC 5'h00
`define REG_DIS_ACC 5'h01
`define REG_CHG_TIME 5'h02
`define REG_DIS_TIME 5'h03
`define REG_SD_CNT 5'h04
`define REG_MODE 5'h05
`define REG_CLEAR 5'h06
`define REG_COMMAND 5'h07
`define REG_GPIO 5'h08
`define REG_LAST 5'h08

`define MODE_CHG_SLOW 0
`define MODE_DIS_SLOW 1
`define MODE_BUSY 2
`define MODE_SLEEP 3
`define CLR_CHG 0
`define CLR_DIS 1
`define CLR_SD 2
`define CLR_ALL 3'h7
`define GPIO_DIR 0
`define GPIO_LEVEL 1
`define GPIO_PIN 2

`define APB_RAM_BIT 7
`define LINK_RAM_BIT 6
`define LINK_WRITE_BIT 7

`define SYN_PULSE 0
`define SYN_POL 1
`define SYN_GPIO 2

`endif

// file: inc/coulomb_pkg.sv
// Purpose: types shared by the charge-accounting core
// Assumes: constants come from the params header
// Notes: one packed state struct per module
`include "coulomb_params.svh"
package coulomb_pkg;
	typedef enum logic [1:0] {
		LINK_RX = 2'b00,
		LINK_WAIT = 2'b01,
		LINK_TX_LOW = 2'b10,
		LINK_TX_HIGH = 2'b11
	} link_phase_t;

	typedef enum logic [7:0] {
		CMD_NONE = 8'h00,
		CMD_SLEEP = 8'h01,
		CMD_REG_RESET = 8'h02,
		CMD_PROGRAM = 8'h03,
		CMD_RECALL = 8'h04
	} command_t;

	typedef struct packed {
		logic [31:0] count;
		logic tick;
	} divider_state_t;

	typedef struct packed {
		logic [2:0] sync;
		logic line;
		link_phase_t phase;
		logic [15:0] cnt;
		logic [7:0] shift;
		logic [3:0] bits;
		logic have_cmd;
		logic [7:0] cmd;
		logic level;
		logic oe;
		logic wr;
		logic rd;
		logic edge_seen;
		logic [6:0] addr;
		logic [7:0] wdata;
	} link_state_t;

	typedef struct packed {
		logic [2:0][2:0] sync;
		logic [2:0] stab;
		logic [15:0] chg_acc;
		logic [15:0] dis_acc;
		logic [15:0] chg_time;
		logic [15:0] dis_time;
		logic [15:0] sd_cnt;
		logic [7:0] chg_pre;
		logic [7:0] dis_pre;
		logic chg_slow;
		logic dis_slow;
		logic [15:0] sd_frac;
		logic [3:0] residual;
		logic chop;
		logic active;
		logic dir_charge;
		logic pulse_seen;
		logic [2:0] clr;
		logic busy;
		logic [15:0] prog_cnt;
		logic sleep;
		logic gpio_dir;
		logic gpio_level;
		logic [`RAM_BYTES-1:0][7:0] ram;
		logic [`RAM_BYTES-1:0][7:0] flash;
		logic pready;
		logic pslverr;
		logic [31:0] prdata;
	} main_state_t;
endpackage : coulomb_pkg

// file: rtl/tick_divider.sv
// Purpose: free-running prescaler from the internal timebase
// Assumes: PERIOD of at least two cycles
// Notes: tick_out is a one-cycle registered pulse
`timescale 1ns/1ps
`include "coulomb_params.svh"
module tick_divider #(
	parameter int unsigned PERIOD = 1000
) (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	output logic tick_out
);
	import coulomb_pkg::*;

	divider_state_t s;
	divider_state_t n;

	always_comb
	begin
		n = s;
		n.tick = 1'b0;
		if (s.count == 32'(PERIOD - 1))
		begin
			n.count = 32'h00000000;
			n.tick = 1'b1;
		end
		else
		begin
			n.count = s.count + 32'h00000001;
		end
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			s <= '0;
		end
		else if (ce_in)
		begin
			s <= n;
		end
	end

	assign tick_out = s.tick;
endmodule : tick_divider

// file: rtl/host_link_engine.sv
// Purpose: bit engine of the single-wire host link
// Assumes: open-drain line, pulled high outside
// Notes: bytes travel lsb first, command msb set means write
`timescale 1ns/1ps
`include "coulomb_params.svh"
module host_link_engine #(
	parameter int unsigned BREAK_CYC = 7600,
	parameter int unsigned RESP_CYC = 10000,
	parameter int unsigned DBIT_CYC = 8800,
	parameter int unsigned DZERO_CYC = 4400
) (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic line_in,
	input wire logic [7:0] rd_data_in,
	output logic line_out,
	output logic line_oe_out,
	output logic wr_out,
	output logic rd_out,
	output logic edge_out,
	output logic [6:0] addr_out,
	output logic [7:0] wdata_out
);
	import coulomb_pkg::*;

	link_state_t s;
	link_state_t n;
	logic fall;
	logic rise;
	logic bit_val;
	logic [7:0] byte_val;
	logic [15:0] low_len;

	always_comb
	begin
		n = s;
		n.wr = 1'b0;
		n.rd = 1'b0;
		n.sync = {s.sync[1:0], line_in};
		// first stage only feeds the second
		if (s.sync[1] == s.sync[2])
		begin
			n.line = s.sync[2];
		end
		fall = s.line & ~n.line;
		rise = ~s.line & n.line;
		n.edge_seen = fall | rise;
		bit_val = s.cnt < `ONE_LIMIT_CYC;
		byte_val = {bit_val, s.shift[7:1]};
		low_len = s.shift[0] ? `DONE_CYC : 16'(DZERO_CYC);
		case (s.phase)
			LINK_RX:
			begin
				if (fall)
				begin
					n.cnt = 16'h0000;
				end
				else if (!s.line && s.cnt != `CNT_MAX)
				begin
					n.cnt = s.cnt + 16'h0001;
				end
				if (rise && s.cnt >= 16'(BREAK_CYC))
				begin
					n.bits = 4'h0;
					n.have_cmd = 1'b0;
				end
				else if (rise)
				begin
					n.shift = byte_val;
					n.bits = s.bits + 4'h1;
					if (s.bits == `BYTE_LAST)
					begin
						n.bits = 4'h0;
						if (s.have_cmd)
						begin
							n.wr = 1'b1;
							n.addr = s.cmd[6:0];
							n.wdata = byte_val;
							n.have_cmd = 1'b0;
						end
						else if (byte_val[`LINK_WRITE_BIT])
						begin
							n.cmd = byte_val;
							n.have_cmd = 1'b1;
						end
						else
						begin
							n.rd = 1'b1;
							n.addr = byte_val[6:0];
							n.cnt = 16'h0000;
							n.phase = LINK_WAIT;
						end
					end
				end
			end
			LINK_WAIT:
			begin
				n.cnt = s.cnt + 16'h0001;
				if (s.cnt == 16'(RESP_CYC - 1))
				begin
					n.shift = rd_data_in;
					n.bits = 4'h0;
					n.cnt = 16'h0000;
					n.oe = 1'b1;
					n.level = 1'b0;
					n.phase = LINK_TX_LOW;
				end
			end
			LINK_TX_LOW:
			begin
				n.cnt = s.cnt + 16'h0001;
				if (s.cnt == low_len - 16'h0001)
				begin
					n.oe = 1'b0;
					n.level = 1'b1;
					n.phase = LINK_TX_HIGH;
				end
			end
			LINK_TX_HIGH:
			begin
				n.cnt = s.cnt + 16'h0001;
				if (s.cnt == 16'(DBIT_CYC - 1))
				begin
					n.cnt = 16'h0000;
					if (s.bits == `BYTE_LAST)
					begin
						n.bits = 4'h0;
						n.phase = LINK_RX;
					end
					else
					begin
						n.bits = s.bits + 4'h1;
						n.shift = {1'b0, s.shift[7:1]};
						n.oe = 1'b1;
						n.level = 1'b0;
						n.phase = LINK_TX_LOW;
					end
				end
			end
			default:
			begin
				n.phase = LINK_RX;
			end
		endcase
	end

	// line idles high, so the synchroniser resets high
	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			s <= '{sync: 3'h7, line: 1'b1, phase: LINK_RX, level: 1'b1, default: '0};
		end
		else if (ce_in)
		begin
			s <= n;
		end
	end

	assign line_out = s.level;
	assign line_oe_out = s.oe;
	assign wr_out = s.wr;
	assign rd_out = s.rd;
	assign edge_out = s.edge_seen;
	assign addr_out = s.addr;
	assign wdata_out = s.wdata;
endmodule : host_link_engine

// file: rtl/coulomb_counter_core.sv
// Purpose: charge, discharge, time and self-discharge counting with register access
// Assumes: converter delivers a pulse per 3.05 uVh and a polarity level
// Notes: registers reachable over APB and over the single-wire link
// What this block does
// - flash program completes within 60 us plus 30 us per byte, max 1020 us.
// - read answer starts 190 to 320 us later; each bit is 40 or 110 us low within a 220 us bit window.
// - a low held for two samples on the link starts a bit; one-sample glitches are filtered.
// - only one accumulator counts, chosen by the sign of the sense voltage.
// - discharge accumulator counts per 3.05 uVh; its time counter at 1.138 per second.
// - charge accumulator counts per 3.05 uVh; its time counter at 1.138 per second.
// - time counters are 16 bits, wrap past ffff and then set their slow flag.
// - with slow flag set a time counter runs at 1/256 rate.
// - self-discharge counter advances once per hour at 25 C.
// - above 25 C its rate doubles per 10 C, limited at 60 C.
// - below 25 C its rate halves per 10 C, limited at 0 C.
// - converter offset is removed internally without host calibration.
// - host reads and writes ram and flash-backed registers over the link.
// - commands: sleep, reset registers, program flash from ram, recall flash.
// - general-purpose pin direction and level set through registers.
// - writing 1 to a clear bit zeroes that counter, then the bit self-clears.
// - clearing a time counter also clears its slow flag and default rate.
// - slow time counter steps every 225 s instead of every 0.8789 s.
//
// Decided for this implementation: the APB register port and the register addresses.
`timescale 1ns/1ps
`include "coulomb_params.svh"
module coulomb_counter_core #(
	parameter int unsigned TICK_CYC = `CEIL_CYC(`TICK_NS),
	parameter int unsigned PROG_CYC = `FLOOR_CYC(`PROG_NS),
	parameter int unsigned BREAK_CYC = `CEIL_CYC(`BREAK_NS),
	parameter int unsigned RESP_CYC = `FLOOR_CYC(`RESP_NS),
	parameter int unsigned DBIT_CYC = `FLOOR_CYC(`DBIT_NS),
	parameter int unsigned DZERO_CYC = `FLOOR_CYC(`DZERO_NS)
) (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic ce_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic pwrite_in,
	input wire logic [7:0] paddr_in,
	input wire logic [31:0] pwdata_in,
	output logic [31:0] prdata_out,
	output logic pready_out,
	output logic pslverr_out,
	input wire logic conv_pulse_in,
	input wire logic conv_polarity_in,
	input wire logic [7:0] die_temp_in,
	input wire logic single_wire_host_link_in,
	output logic single_wire_host_link_out,
	output logic single_wire_host_link_oe_out,
	input wire logic gpio_in,
	output logic gpio_out,
	output logic gpio_oe_out,
	output logic chop_out,
	output logic sleep_out,
	output logic flash_busy_out
);
	import coulomb_pkg::*;

	main_state_t s;
	main_state_t n;
	logic tick;
	logic link_wr;
	logic link_rd;
	logic link_edge;
	logic [6:0] link_addr;
	logic [7:0] link_wdata;
	logic [7:0] link_rd_data;
	logic [15:0] link_word;
	logic [4:0] link_idx;
	logic [4:0] apb_idx;
	logic apb_ram;
	logic apb_mapped;
	logic apb_access;
	logic pulse_evt;
	logic true_pos;
	logic [16:0] sd_sum;
	logic [1:0] wr_en;
	logic [1:0] wr_ram;
	logic [1:0][4:0] wr_idx;
	logic [1:0][7:0] wr_data;

	function automatic logic [15:0] read_word(main_state_t st, logic ram_sel, logic [4:0] idx);
		logic [15:0] v;
		v = 16'h0000;
		if (ram_sel)
		begin
			v = {8'h00, st.ram[idx]};
		end
		else
		begin
			case (idx)
				`REG_CHG_ACC: v = st.chg_acc;
				`REG_DIS_ACC: v = st.dis_acc;
				`REG_CHG_TIME: v = st.chg_time;
				`REG_DIS_TIME: v = st.dis_time;
				`REG_SD_CNT: v = st.sd_cnt;
				`REG_MODE:
				begin
					v[`MODE_CHG_SLOW] = st.chg_slow;
					v[`MODE_DIS_SLOW] = st.dis_slow;
					v[`MODE_BUSY] = st.busy;
					v[`MODE_SLEEP] = st.sleep;
				end
				`REG_CLEAR: v = {13'h0000, st.clr};
				`REG_GPIO:
				begin
					v[`GPIO_DIR] = st.gpio_dir;
					v[`GPIO_LEVEL] = st.gpio_level;
					v[`GPIO_PIN] = st.stab[`SYN_GPIO];
				end
				default: v = 16'h0000;
			endcase
		end
		return v;
	endfunction : read_word

	// one tick step of a time counter, slow mode waits 256 ticks
	function automatic logic [24:0] time_step(logic slow, logic [7:0] pre, logic [15:0] cnt);
		logic s2;
		logic [7:0] p2;
		logic [15:0] c2;
		s2 = slow;
		p2 = pre;
		c2 = cnt;
		if (slow && pre != `SLOW_LAST)
		begin
			p2 = pre + 8'h01;
		end
		else
		begin
			p2 = 8'h00;
			c2 = cnt + 16'h0001;
			if (cnt == `CNT_MAX)
			begin
				s2 = 1'b1;
			end
		end
		return {s2, p2, c2};
	endfunction : time_step

	// weight per tick; 4096 ticks of nominal weight fill the 16-bit fraction
	function automatic logic [15:0] sd_weight(logic [7:0] temp);
		int t;
		t = int'($signed(temp));
		if (t < `SD_T_MIN)
		begin
			t = `SD_T_MIN;
		end
		if (t > `SD_T_MAX)
		begin
			t = `SD_T_MAX;
		end
		if (t >= `SD_T_NOM)
		begin
			return 16'(`SD_W_NOM << ((t - `SD_T_NOM) / `SD_T_STEP));
		end
		return 16'(`SD_W_NOM >> ((`SD_T_NOM - t + `SD_T_STEP - 1) / `SD_T_STEP));
	endfunction : sd_weight

	tick_divider #(
		.PERIOD(TICK_CYC)
	) u_tick (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.ce_in(ce_in),
		.tick_out(tick)
	);

	host_link_engine #(
		.BREAK_CYC(BREAK_CYC),
		.RESP_CYC(RESP_CYC),
		.DBIT_CYC(DBIT_CYC),
		.DZERO_CYC(DZERO_CYC)
	) u_link (
		.sys_clk_in(sys_clk_in),
		.rst_in(rst_in),
		.ce_in(ce_in),
		.line_in(single_wire_host_link_in),
		.rd_data_in(link_rd_data),
		.line_out(single_wire_host_link_out),
		.line_oe_out(single_wire_host_link_oe_out),
		.wr_out(link_wr),
		.rd_out(link_rd),
		.edge_out(link_edge),
		.addr_out(link_addr),
		.wdata_out(link_wdata)
	);

	// link address: upper half is ram, lower half is register bytes
	assign link_idx = link_addr[`LINK_RAM_BIT] ? link_addr[4:0] : {1'b0, link_addr[4:1]};
	assign link_word = read_word(s, link_addr[`LINK_RAM_BIT], link_idx);
	assign link_rd_data = (link_addr[`LINK_RAM_BIT] || !link_addr[0]) ? link_word[7:0] : link_word[15:8];
	assign apb_ram = paddr_in[`APB_RAM_BIT];
	assign apb_idx = paddr_in[6:2];
	assign apb_mapped = apb_ram || apb_idx <= `REG_LAST;
	assign apb_access = psel_in && penable_in;

	always_comb
	begin
		n = s;
		n.pready = 1'b0;
		for (int k = 0; k < 3; k++)
		begin
			n.sync[k] = {s.sync[k][1:0], (k == `SYN_PULSE) ? conv_pulse_in :
				(k == `SYN_POL) ? conv_polarity_in : gpio_in};
			if (s.sync[k][1] == s.sync[k][2])
			begin
				n.stab[k] = s.sync[k][2];
			end
		end
		pulse_evt = n.stab[`SYN_PULSE] && !s.stab[`SYN_PULSE];
		// chopping swaps converter polarity, so its offset alternates sign and cancels
		true_pos = s.stab[`SYN_POL] ^ s.chop;
		sd_sum = {1'b0, s.sd_frac} + {1'b0, sd_weight(die_temp_in)};

		if (tick)
		begin
			n.chop = !s.chop;
			n.active = s.pulse_seen;
			n.pulse_seen = 1'b0;
			n.sd_frac = sd_sum[15:0];
			if (sd_sum[16])
			begin
				n.sd_cnt = s.sd_cnt + 16'h0001;
			end
			if (s.active && !s.sleep && s.dir_charge)
			begin
				{n.chg_slow, n.chg_pre, n.chg_time} = time_step(s.chg_slow, s.chg_pre, s.chg_time);
			end
			if (s.active && !s.sleep && !s.dir_charge)
			begin
				{n.dis_slow, n.dis_pre, n.dis_time} = time_step(s.dis_slow, s.dis_pre, s.dis_time);
			end
		end

		// residual absorbs small alternating offset before any count is made
		if (pulse_evt && !s.sleep)
		begin
			n.pulse_seen = 1'b1;
			n.dir_charge = true_pos;
			if (true_pos && s.residual == `RES_POS)
			begin
				n.chg_acc = s.chg_acc + 16'h0001;
			end
			else if (true_pos)
			begin
				n.residual = s.residual + 4'h1;
			end
			else if (s.residual == `RES_NEG)
			begin
				n.dis_acc = s.dis_acc + 16'h0001;
			end
			else
			begin
				n.residual = s.residual - 4'h1;
			end
		end

		if (s.clr[`CLR_CHG])
		begin
			n.chg_acc = 16'h0000;
			n.chg_time = 16'h0000;
			n.chg_pre = 8'h00;
			n.chg_slow = 1'b0;
			n.clr[`CLR_CHG] = 1'b0;
		end
		if (s.clr[`CLR_DIS])
		begin
			n.dis_acc = 16'h0000;
			n.dis_time = 16'h0000;
			n.dis_pre = 8'h00;
			n.dis_slow = 1'b0;
			n.clr[`CLR_DIS] = 1'b0;
		end
		if (s.clr[`CLR_SD])
		begin
			n.sd_cnt = 16'h0000;
			n.sd_frac = 16'h0000;
			n.clr[`CLR_SD] = 1'b0;
		end

		if (s.busy)
		begin
			n.prog_cnt = s.prog_cnt + 16'h0001;
			if (s.prog_cnt == 16'(PROG_CYC - 1))
			begin
				n.flash = s.ram;
				n.busy = 1'b0;
			end
		end
		if (link_edge)
		begin
			n.sleep = 1'b0;
		end

		if (apb_access && !s.pready)
		begin
			n.pready = 1'b1;
			n.pslverr = !apb_mapped;
			n.prdata = (apb_mapped && !pwrite_in) ? {16'h0000, read_word(s, apb_ram, apb_idx)} : 32'h00000000;
		end

		// writes land after hardware clears so a new set wins
		wr_en = {apb_access && s.pready && pwrite_in && apb_mapped, link_wr};
		wr_ram = {apb_ram, link_addr[`LINK_RAM_BIT]};
		wr_idx = {apb_idx, link_idx};
		wr_data = {pwdata_in[7:0], link_wdata};
		for (int k = 0; k < 2; k++)
		begin
			if (wr_en[k] && wr_ram[k])
			begin
				n.ram[wr_idx[k]] = wr_data[k];
			end
			else if (wr_en[k] && wr_idx[k] == `REG_CLEAR)
			begin
				n.clr = n.clr | wr_data[k][2:0];
			end
			else if (wr_en[k] && wr_idx[k] == `REG_GPIO)
			begin
				n.gpio_dir = wr_data[k][`GPIO_DIR];
				n.gpio_level = wr_data[k][`GPIO_LEVEL];
			end
			else if (wr_en[k] && wr_idx[k] == `REG_COMMAND && !n.busy)
			begin
				case (command_t'(wr_data[k]))
					CMD_SLEEP: n.sleep = 1'b1;
					CMD_REG_RESET:
					begin
						n.clr = `CLR_ALL;
						n.gpio_dir = 1'b0;
						n.gpio_level = 1'b0;
						n.sleep = 1'b0;
					end
					CMD_PROGRAM:
					begin
						n.busy = 1'b1;
						n.prog_cnt = 16'h0000;
					end
					CMD_RECALL: n.ram = s.flash;
					default: n.busy = n.busy;
				endcase
			end
		end
	end

	always_ff @(posedge sys_clk_in)
	begin
		if (rst_in)
		begin
			s <= '0;
		end
		else if (ce_in)
		begin
			s <= n;
		end
	end

	assign prdata_out = s.prdata;
	assign pready_out = s.pready;
	assign pslverr_out = s.pslverr;
	assign gpio_out = s.gpio_level;
	assign gpio_oe_out = s.gpio_dir;
	assign chop_out = s.chop;
	assign sleep_out = s.sleep;
	assign flash_busy_out = s.busy;
endmodule : coulomb_counter_core

// file: dv/coulomb_counter_core_checker.sv
// Purpose: port checker of the charge-accounting core
// Assumes: one clock, ce_in held high by the bench
// Notes: long lengths are counted in helper logic
`timescale 1ns/1ps
module coulomb_counter_core_checker #(
	parameter int unsigned PROG_CYC = 40,
	parameter int unsigned DBIT_CYC = 8800,
	parameter int unsigned DZERO_CYC = 4400
) (
	input wire logic sys_clk_in,
	input wire logic rst_in,
	input wire logic psel_in,
	input wire logic penable_in,
	input wire logic [31:0] prdata_out,
	input wire logic pready_out,
	input wire logic single_wire_host_link_out,
	input wire logic single_wire_host_link_oe_out,
	input wire logic chop_out,
	input wire logic flash_busy_out
);
	logic [15:0] hi_cnt;
	logic [15:0] lo_cnt;
	logic [15:0] busy_cnt;
	// counters, too long to unroll as repetitions
	always_ff @(posedge sys_clk_in)
	begin
		hi_cnt <= single_wire_host_link_oe_out ? hi_cnt + 16'h0001 : 16'h0000;
		lo_cnt <= (single_wire_host_link_oe_out || rst_in) ? 16'h0000 : lo_cnt + 16'(lo_cnt != 16'hffff);
		busy_cnt <= flash_busy_out ? busy_cnt + 16'h0001 : 16'h0000;
	end
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (rst_in);
	apb_answer_a: assert property (psel_in && penable_in && !pready_out |=> pready_out)
		else $error("access phase not answered");
	ready_once_a: assert property (pready_out |=> !pready_out)
		else $error("ready longer than one cycle");
	ready_cause_a: assert property (pready_out |-> $past(psel_in && penable_in))
		else $error("ready without access");
	upper_zero_a: assert property (pready_out |-> prdata_out[31:16] == 16'h0000)
		else $error("read data above bit 15");
	chop_rate_a: assert property ($changed(chop_out) |=> $stable(chop_out) [*8])
		else $error("chop toggles too fast");
	drive_low_a: assert property (single_wire_host_link_oe_out |-> !single_wire_host_link_out)
		else $error("link driven high");
	low_len_a: assert property ($fell(single_wire_host_link_oe_out) |-> hi_cnt == 16'h0640 || hi_cnt == 16'(DZERO_CYC))
		else $error("answer bit low time wrong");
	// the bit window counts low and high time together
	bit_gap_a: assert property ($rose(single_wire_host_link_oe_out) |-> lo_cnt >= 16'(DBIT_CYC - DZERO_CYC))
		else $error("answer bit window short");
	busy_len_a: assert property ($fell(flash_busy_out) |-> busy_cnt == 16'(PROG_CYC))
		else $error("flash busy length wrong");
endmodule : coulomb_counter_core_checker

bind coulomb_counter_core coulomb_counter_core_checker #(.PROG_CYC(PROG_CYC), .DBIT_CYC(DBIT_CYC), .DZERO_CYC(DZERO_CYC))
	checker_i (.sys_clk_in(sys_clk_in), .rst_in(rst_in), .psel_in(psel_in), .penable_in(penable_in),
	.prdata_out(prdata_out), .pready_out(pready_out), .single_wire_host_link_out(single_wire_host_link_out),
	.single_wire_host_link_oe_out(single_wire_host_link_oe_out), .chop_out(chop_out), .flash_busy_out(flash_busy_out));

// file: dv/host_link_model.sv
// Purpose: host end of the single-wire link
// Assumes: line pulled high, pull_out high pulls it low
// Notes: times in system clock cycles
`timescale 1ns/1ps
module host_link_model #(
	parameter int unsigned ONE_LOW = 1400,
	parameter int unsigned ZERO_LOW = 4400,
	parameter int unsigned WINDOW = 7600
) (
	input wire logic clk_in,
	input wire logic line_in,
	output logic pull_out
);
	initial pull_out = 1'b0;
	// clean edges only, never a glitch
	task automatic low_high(input int lo, input int hi);
		pull_out <= 1'b1;
		repeat (lo) @(posedge clk_in);
		pull_out <= 1'b0;
		repeat (hi) @(posedge clk_in);
	endtask : low_high
	task automatic read_byte(input logic [7:0] addr, output logic [7:0] data, output int gap);
		int n;
		int lo;
		low_high(7800, 1600);
		for (int i = 0; i < 8; i++)
		begin
			lo = addr[i] ? ONE_LOW : ZERO_LOW;
			// one edge after the last release, so the line already reads high
			low_high(lo, i == 7 ? 1 : WINDOW - lo);
		end
		for (int i = 0; i < 8; i++)
		begin
			n = 0;
			while (line_in && n < 20000)
			begin
				@(posedge clk_in);
				n++;
			end
			if (i == 0)
				gap = n;
			n = 0;
			while (!line_in && n < 8000)
			begin
				@(posedge clk_in);
				n++;
			end
			data[i] = n < 2400;
		end
	endtask : read_byte
endmodule : host_link_model

// file: dv/coulomb_counter_core_bench.sv
// Purpose: self-checking bench of the charge-accounting core
// Assumes: host model on the link, APB master here
// Notes: link read runs beside the register work to save time
`timescale 1ns/1ps
`include "coulomb_params.svh"
module coulomb_counter_core_bench;
	import coulomb_pkg::*;
	localparam int unsigned TICK = 50;
	localparam int unsigned PROG = 40;
	localparam int unsigned RESP = 400;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic psel = 1'b0, pen = 1'b0, pwr = 1'b0, pulse = 1'b0, sign = 1'b0, pin = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [7:0] temp = 8'h19;
	logic [31:0] pwdata = 32'h0;
	logic [31:0] prdata, rv;
	logic pready, perr, ev, pull, link_out, link_oe, gp_out, gp_oe, chop, sleep, busy;
	wire line = !(pull || link_oe);
	wire pol = sign ^ chop;
	int fail_count = 0;
	int num_checks = 0;
	int cyc = 0;
	logic [31:0] seed = 32'h25;
	coulomb_counter_core #(.TICK_CYC(TICK), .PROG_CYC(PROG), .RESP_CYC(RESP), .DBIT_CYC(3400), .DZERO_CYC(3200)) dut (
		.sys_clk_in(clk), .rst_in(rst), .ce_in(1'b1), .psel_in(psel), .penable_in(pen), .pwrite_in(pwr),
		.paddr_in(paddr), .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready), .pslverr_out(perr),
		.conv_pulse_in(pulse), .conv_polarity_in(pol), .die_temp_in(temp), .single_wire_host_link_in(line),
		.single_wire_host_link_out(link_out), .single_wire_host_link_oe_out(link_oe), .gpio_in(pin),
		.gpio_out(gp_out), .gpio_oe_out(gp_oe), .chop_out(chop), .sleep_out(sleep), .flash_busy_out(busy));
	host_link_model host (.clk_in(clk), .line_in(line), .pull_out(pull));
	function logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction : rnd
	function automatic logic [7:0] ra(input logic [4:0] i);
		return {1'b0, i, 2'b00};
	endfunction : ra
	function automatic logic [7:0] ma(input logic [4:0] i);
		return {1'b1, i, 2'b00};
	endfunction : ma
	function automatic int sd_weight(input int t);
		int w;
		w = 16;
		for (int d = 25; d < t && d < 55; d += 10) w *= 2;
		for (int d = 25; d > t && d > 0; d -= 10) w /= 2;
		return w;
	endfunction : sd_weight
	task automatic test_done;
		$display("checks %0d mismatches %0d", num_checks, fail_count);
		if (fail_count == 0 && num_checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : test_done
	task automatic chk(input logic [31:0] g, input logic [31:0] x);
		num_checks++;
		if (g !== x)
		begin
			fail_count++;
			$display("BAD at %0t got %h expected %h", $time, g, x);
		end
	endtask : chk
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		psel <= 1'b1;
		pwr <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		pen <= 1'b1;
		do
		begin
			@(posedge clk);
		end
		while (pready !== 1'b1);
		rv = prdata;
		ev = perr;
		psel <= 1'b0;
		pen <= 1'b0;
	endtask : apb
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask : wr
	task automatic rdc(input logic [7:0] a, input logic [31:0] x);
		apb(1'b0, a, 32'h0);
		chk(rv, x);
	endtask : rdc
	// one pulse per tick, kept clear of the chop turn
	task automatic pulses(input logic s, input int cnt);
		int n;
		logic c;
		sign <= s;
		repeat (cnt)
		begin
			c = chop;
			n = 0;
			while (chop === c && n < 100)
			begin
				@(posedge clk);
				n++;
			end
			repeat (10) @(posedge clk);
			pulse <= 1'b1;
			repeat (4) @(posedge clk);
			pulse <= 1'b0;
		end
	endtask : pulses
	initial
	begin
		forever #12.5 clk = ~clk;
	end
	always @(posedge clk)
	begin
		cyc <= cyc + 1;
		if (cyc == 100000)
		begin
			fail_count++;
			test_done;
		end
	end
	initial
	begin
		logic [7:0] v;
		logic [7:0] got;
		int gap;
		int n;
		int k;
		repeat (10) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 9; i++)
			if (i != 7)
				rdc(ra(5'(i)), 32'h0);
		apb(1'b0, ra(5'(9 + rnd() % 23)), 32'h0);
		chk({31'h0, ev}, 32'h1);
		v = 8'(rnd());
		wr(ma(5'h05), {24'h0, v});
		rdc(ma(5'h05), {24'h0, v});
		fork
			begin
				host.read_byte(8'h45, got, gap);
				chk({24'h0, got}, {24'h0, v});
				chk(32'(gap >= RESP && gap <= RESP + 8), 32'h1);
			end
			begin
				k = 2 + rnd() % 6;
				pulses(1'b1, 3 + k);
				rdc(ra(`REG_CHG_ACC), k);
				// six pulses carry the residual from +3 to -3 first
				pulses(1'b0, 7 + k);
				rdc(ra(`REG_DIS_ACC), k + 1);
				rdc(ra(`REG_CHG_ACC), k);
				apb(1'b0, ra(`REG_DIS_TIME), 32'h0);
				chk(32'(rv != 32'h0), 32'h1);
				repeat (2 * TICK) @(posedge clk);
				wr(ra(`REG_CLEAR), 32'h3);
				for (int i = 0; i < 4; i++)
					rdc(ra(5'(i)), 32'h0);
				rdc(ra(`REG_CLEAR), 32'h0);
				for (int g = 0; g < 4; g++)
				begin
					pin <= ~g[0];
					wr(ra(`REG_GPIO), g);
					repeat (4) @(posedge clk);
					chk({30'h0, gp_out, gp_oe}, g);
					rdc(ra(`REG_GPIO), {29'h0, ~g[0], 2'(g)});
				end
				wr(ra(`REG_COMMAND), CMD_PROGRAM);
				rdc(ra(`REG_MODE), 32'h4);
				n = 0;
				while (busy !== 1'b0 && n < 200)
				begin
					@(posedge clk);
					n++;
				end
				chk(32'(n < PROG), 32'h1);
				wr(ma(5'h05), {24'h0, ~v});
				wr(ra(`REG_COMMAND), CMD_RECALL);
				rdc(ma(5'h05), {24'h0, v});
				pin <= 1'b0;
				wr(ra(`REG_GPIO), 32'h3);
				wr(ra(`REG_COMMAND), CMD_REG_RESET);
				rdc(ra(`REG_GPIO), 32'h0);
				temp <= 8'h41;
				wr(ra(`REG_CLEAR), 32'h4);
				repeat (600 * TICK) @(posedge clk);
				rdc(ra(`REG_SD_CNT), 32'((600 * sd_weight(65)) >> 16));
				wr(ra(`REG_COMMAND), CMD_SLEEP);
				repeat (2) @(posedge clk);
				chk({31'h0, sleep}, 32'h1);
			end
		join
		// later link edges must have woken it
		chk({31'h0, sleep}, 32'h0);
		test_done;
	end
endmodule : coulomb_counter_core_bench
